/* hw/ipbg_top.sv */
// Function
// - Sixteen groups, two address qualifiers each
// - Pair works as two equals or range
// - Only instruction pointer is compared
// - All group matches ORed together
// - Gating needs selected level 1..6 true
// - One enable switches level gating
// - Sync delays address events to data
// - Per-qualifier enable; disabled never matches
// - Range: low <= ip < high
// - Trigger action raises o_trigger; o_record is not stopped by it
// - Record action while range true
// - Flag set or cleared by range
// - Range break halts emulation
// - Equality compares each qualifier separately
// - Equality record per qualifier
// - Equality break per qualifier
// - Runs alongside CPU, no stalls
`timescale 1ns/1ps
`default_nettype none
`include "ipbg_map.svh"

module ipbg_top (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Processor side
  input  wire logic [23:0]            i_ip,
  input  wire logic                   i_ip_valid,
  input  wire logic [5:0]             i_level_true,
  // Group qualifiers
  input  wire logic [16*24-1:0]       i_first_address_qualifier,
  input  wire logic [16*24-1:0]       i_second_address_qualifier,
  input  wire ipbg_pkg::ipbg_grp_t    i_qual_one_en,
  input  wire ipbg_pkg::ipbg_grp_t    i_qual_two_en,
  input  wire ipbg_pkg::ipbg_grp_t    i_range_mode,
  // Range actions
  input  wire ipbg_pkg::ipbg_grp_t    i_rng_trigger,
  input  wire ipbg_pkg::ipbg_grp_t    i_rng_record,
  input  wire ipbg_pkg::ipbg_grp_t    i_rng_flag_on,
  input  wire ipbg_pkg::ipbg_grp_t    i_rng_flag_off,
  input  wire ipbg_pkg::ipbg_grp_t    i_rng_break,
  // Equality actions
  input  wire ipbg_pkg::ipbg_grp_t    i_eq_rec_one,
  input  wire ipbg_pkg::ipbg_grp_t    i_eq_rec_two,
  input  wire ipbg_pkg::ipbg_grp_t    i_eq_brk_one,
  input  wire ipbg_pkg::ipbg_grp_t    i_eq_brk_two,
  // Global conditions
  input  wire logic                   i_gate_en,
  input  wire logic [2:0]             i_gate_level,
  input  wire logic                   i_sync_en,
  // Results
  output logic                        o_group_event,
  output logic                        o_trigger,
  output logic                        o_record,
  output logic                        o_user_flag,
  output logic                        o_break
);

  // -------------------------------------------------------------------------
  // Comparators
  // -------------------------------------------------------------------------

  // Equality test of one qualifier against the pointer
  function automatic logic ipbg_eq(input logic [23:0] a,
                                   input logic [23:0] ip);
    ipbg_eq = (a == ip);
  endfunction : ipbg_eq

  logic [15:0] eq_one;
  logic [15:0] eq_two;
  logic [15:0] rng_hit;
  logic [15:0] grp_hit;
  logic        gate_ok;

  always_comb begin
    gate_ok = 1'b1;
    if (i_gate_en) begin
      if (i_gate_level >= 3'h1 && i_gate_level <= 3'h6) begin
        gate_ok = i_level_true[i_gate_level - 3'h1];
      end else begin
        gate_ok = 1'b0;
      end
    end
  end

  // Per-group comparison; only the pointer is compared, never bus data
  always_comb begin
    for (int g = 0; g < 16; g++) begin
      logic [23:0] lo;
      logic [23:0] hi;
      lo = i_first_address_qualifier[g*24 +: 24];
      hi = i_second_address_qualifier[g*24 +: 24];
      eq_one[g] = ~i_range_mode[g] & i_qual_one_en[g] & ipbg_eq(lo, i_ip);
      eq_two[g] = ~i_range_mode[g] & i_qual_two_en[g] & ipbg_eq(hi, i_ip);
      rng_hit[g] = i_range_mode[g] & i_qual_one_en[g] & i_qual_two_en[g]
                   & (i_ip >= lo) & (i_ip < hi);
      grp_hit[g] = (rng_hit[g] | eq_one[g] | eq_two[g]) & gate_ok
                   & i_ip_valid;
    end
  end

  // -------------------------------------------------------------------------
  // Action combine
  // -------------------------------------------------------------------------
  logic m_event;
  logic m_trig;
  logic m_rec;
  logic m_set;
  logic m_clr;
  logic m_brk;

  always_comb begin
    m_event = |grp_hit;
    m_trig  = |(grp_hit & i_range_mode & i_rng_trigger);
    m_rec   = |(grp_hit & i_range_mode & i_rng_record)
            | |(grp_hit & eq_one & i_eq_rec_one)
            | |(grp_hit & eq_two & i_eq_rec_two);
    m_set   = |(grp_hit & i_range_mode & i_rng_flag_on);
    m_clr   = |(grp_hit & i_range_mode & i_rng_flag_off);
    m_brk   = |(grp_hit & i_range_mode & i_rng_break)
            | |(grp_hit & eq_one & i_eq_brk_one)
            | |(grp_hit & eq_two & i_eq_brk_two);
  end

  // -------------------------------------------------------------------------
  // Sync alignment
  // -------------------------------------------------------------------------
  // Data qualifiers resolve later than pointer events; a fixed pipe
  // delays events that were already ANDed with the level of the pointer cycle.
  logic [5:0] stg_r [`IPBG_SYNC_DLY];
  logic [5:0] now_v;
  logic [5:0] sel_v;

  assign now_v = {m_event, m_trig, m_rec, m_set, m_clr, m_brk};

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < `IPBG_SYNC_DLY; k++) begin
        stg_r[k] <= 6'h00;
      end
    end else begin
      stg_r[0] <= now_v;
      for (int k = 1; k < `IPBG_SYNC_DLY; k++) begin
        stg_r[k] <= stg_r[k-1];
      end
    end
  end

  assign sel_v = i_sync_en ? stg_r[`IPBG_SYNC_DLY-1] : now_v;

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  // pure observer, no stall
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_group_event <= 1'b0;
      o_trigger     <= 1'b0;
      o_record      <= 1'b0;
      o_break       <= 1'b0;
    end else begin
      o_group_event <= sel_v[5];
      o_trigger     <= sel_v[4];
      o_record      <= sel_v[3];
      o_break       <= sel_v[0];
    end
  end

  // Set wins when both set and clear hit in one cycle
  // user flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_user_flag <= `IPBG_FLAG_RST;
    end else if (sel_v[2]) begin
      o_user_flag <= 1'b1;
    end else if (sel_v[1]) begin
      o_user_flag <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  range_break_a: assert property (
    (!i_sync_en && m_brk) |=> o_break)
    else $error("break not raised");
  group_or_a: assert property (
    (!i_sync_en && |grp_hit) |=> o_group_event)
    else $error("group event missing");
  gate_block_a: assert property (
    (!i_sync_en && i_gate_en && !gate_ok) |=> !o_group_event)
    else $error("gated event leaked");
  gate_off_a: assert property (
    !i_gate_en |-> gate_ok)
    else $error("gate active while off");
  sync_delay_a: assert property (
    (i_sync_en [*3] ##0 $past(m_event, 2)) |=> o_group_event)
    else $error("sync delay wrong");
  both_off_a: assert property (
    ((~i_qual_one_en & ~i_qual_two_en) == 16'hFFFF) |-> (grp_hit == 16'h0000))
    else $error("disabled group hit");
  flag_set_a: assert property (
    (!i_sync_en && m_set) |=> o_user_flag)
    else $error("flag not set");
  flag_clr_a: assert property (
    (!i_sync_en && m_clr && !m_set) |=> !o_user_flag)
    else $error("flag not cleared");
  trig_a: assert property (
    (!i_sync_en && m_trig) |=> o_trigger)
    else $error("trigger missing");

  // -------------------------------------------------------------------------
  // Reference model for checks
  // -------------------------------------------------------------------------
  // Second reading of the match rules, written per mode and per qualifier,
  // so that a slip in the main comparator shows up as a mismatch here.
  // Kept apart from the datapath; it drives no output.
  logic [`IPBG_NUM_GROUPS-1:0] ref_hit;
  logic                        ref_lvl;

  // Level gate seen as a search over the six levels
  always_comb begin
    ref_lvl = !i_gate_en;
    for (int n = 1; n <= `IPBG_NUM_LEVELS; n++) begin
      if (i_gate_en && (i_gate_level == n[2:0]) && i_level_true[n-1]) begin
        ref_lvl = 1'b1;
      end
    end
  end

  // Per group: range needs both enables, equality each one alone
  always_comb begin
    ref_hit = '0;
    for (int g = 0; g < `IPBG_NUM_GROUPS; g++) begin
      logic [`IPBG_ADDR_W-1:0] lo_v;
      logic [`IPBG_ADDR_W-1:0] hi_v;
      lo_v = i_first_address_qualifier[g*`IPBG_ADDR_W +: `IPBG_ADDR_W];
      hi_v = i_second_address_qualifier[g*`IPBG_ADDR_W +: `IPBG_ADDR_W];
      if (i_ip_valid && ref_lvl) begin
        if (i_range_mode[g]) begin
          ref_hit[g] = i_qual_one_en[g] && i_qual_two_en[g]
                       && !(i_ip < lo_v) && !(i_ip >= hi_v);
        end else begin
          ref_hit[g] = (i_qual_one_en[g] && (i_ip == lo_v))
                       || (i_qual_two_en[g] && (i_ip == hi_v));
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Further assertions
  // -------------------------------------------------------------------------
  // Six of these look only with sync off, where the latency is one cycle;
  // the sync path has its own checks.

  ref_match_a: assert property (
    grp_hit == ref_hit)
    else $error("group match differs from reference");

  no_valid_a: assert property (
    (!i_sync_en && !i_ip_valid) |=> !o_group_event)
    else $error("event without valid pointer");

  record_a: assert property (
    (!i_sync_en && m_rec) |=> o_record)
    else $error("record not raised");

  eq_break_a: assert property (
    (!i_sync_en && |(eq_one & i_eq_brk_one & grp_hit)) |=> o_break)
    else $error("equality break missing");

  eq_record_a: assert property (
    (!i_sync_en && |(eq_two & i_eq_rec_two & grp_hit)) |=> o_record)
    else $error("equality record missing");

  quiet_a: assert property (
    (!i_sync_en && !m_event)
      |=> !(o_group_event | o_trigger | o_record | o_break))
    else $error("action without event");

  flag_hold_a: assert property (
    (!i_sync_en && !m_set && !m_clr) |=> $stable(o_user_flag))
    else $error("flag moved without action");

  sync_hold_a: assert property (
    (i_sync_en && !stg_r[`IPBG_SYNC_DLY-1][5]) |=> !o_group_event)
    else $error("sync event not from pipe");

  gate_level_a: assert property (
    (i_gate_en && |grp_hit) |-> ref_lvl)
    else $error("gated hit without level");

  any_group_a: assert property (
    (i_ip_valid && gate_ok && |(eq_one | eq_two | rng_hit)) |-> m_event)
    else $error("group hit not merged");

  reset_quiet_a: assert property (
    disable iff (1'b0) !i_rst_n
      |=> !(o_group_event | o_trigger | o_record | o_break | o_user_flag))
    else $error("output active after reset");

  range_c: cover property (|rng_hit ##1 o_break);
  gate_c:  cover property (i_gate_en && |grp_hit ##1 o_group_event);
  eq_c:    cover property (|eq_one ##1 o_record);
  flag_c:  cover property (o_user_flag ##[1:20] !o_user_flag);
  sync_c:  cover property (i_sync_en && m_event ##2 o_group_event);

endmodule : ipbg_top

`default_nettype wire

/* inc/ipbg_map.svh */
`ifndef IPBG_MAP_SVH
`define IPBG_MAP_SVH

// ---------------------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------------------
`define IPBG_NUM_GROUPS  16
`define IPBG_ADDR_W      24
`define IPBG_LVL_W       3
`define IPBG_NUM_LEVELS  6

// ---------------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------------
`define IPBG_FLAG_RST    1'h0
`define IPBG_SYNC_DLY    2

`endif

/* inc/ipbg_pkg.sv */
package ipbg_pkg;
  typedef logic [23:0] ipbg_addr_t;
  typedef logic [15:0] ipbg_grp_t;
endpackage : ipbg_pkg

/* tb/ipbg_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Pointer source; an idle bus shows the inverted stale pointer
module ipbg_cpu_model (
  input  wire logic        i_clk,
  input  wire logic [23:0] i_want,
  input  wire logic        i_want_v,
  output logic      [23:0] o_ip,
  output logic             o_ip_valid
);
  logic [23:0] last_r;
  // Remember what was shown last
  always_ff @(posedge i_clk) begin
    last_r <= o_ip;
  end
  // A held value could hide a stale match, so invert it
  assign o_ip = i_want_v ? i_want : ~last_r;
  assign o_ip_valid = i_want_v;
endmodule : ipbg_cpu_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // --------
  // Signals
  // --------
  logic                i_clk = 1'h0;
  logic                i_rst_n, want_v, i_ip_valid;
  logic [23:0]         want, i_ip;
  logic [5:0]          i_level_true;
  logic [383:0]        i_first_address_qualifier;
  logic [383:0]        i_second_address_qualifier;
  logic                i_gate_en, i_sync_en;
  logic [2:0]          i_gate_level;
  logic                o_group_event, o_trigger, o_record;
  logic                o_user_flag, o_break;
  ipbg_pkg::ipbg_grp_t i_qual_one_en, i_qual_two_en, i_range_mode,
                       i_rng_trigger, i_rng_record, i_rng_flag_on,
                       i_rng_flag_off, i_rng_break, i_eq_rec_one,
                       i_eq_rec_two, i_eq_brk_one, i_eq_brk_two;
  int                  n_errors = 0;
  int                  n_tests = 0;

  ipbg_top ipbg_top_i (.i_clk, .i_rst_n, .i_ip, .i_ip_valid,
    .i_level_true, .i_first_address_qualifier,
    .i_second_address_qualifier, .i_qual_one_en, .i_qual_two_en,
    .i_range_mode, .i_rng_trigger, .i_rng_record, .i_rng_flag_on,
    .i_rng_flag_off, .i_rng_break, .i_eq_rec_one, .i_eq_rec_two,
    .i_eq_brk_one, .i_eq_brk_two, .i_gate_en, .i_gate_level,
    .i_sync_en, .o_group_event, .o_trigger, .o_record, .o_user_flag,
    .o_break);
  ipbg_cpu_model ipbg_cpu_model_i (.i_clk, .i_want(want),
    .i_want_v(want_v), .o_ip(i_ip), .o_ip_valid(i_ip_valid));

  // 125 MHz clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // One pointer cycle, outputs looked at one cycle later
  task automatic step(input logic [23:0] ip, input logic v,
                      input logic [4:0] exp);
    logic [4:0] got;
    want = ip;
    want_v = v;
    @(negedge i_clk);
    got = {o_group_event, o_trigger, o_record, o_user_flag, o_break};
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : step

  // Verdict and end of run
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Groups: 5 eq break, 15 eq record, 3 and 4 ranges, 7 disabled
  initial begin
    {i_rst_n, want, want_v, i_level_true, i_gate_en} = '0;
    {i_gate_level, i_sync_en, i_eq_rec_one, i_eq_brk_two} = '0;
    i_first_address_qualifier = '0;
    i_second_address_qualifier = 384'h0;
    i_first_address_qualifier[5*24+:24] = 24'h000446;
    i_second_address_qualifier[15*24+:24] = 24'h00A000;
    i_first_address_qualifier[3*24+:24] = 24'h000100;
    i_second_address_qualifier[3*24+:24] = 24'h000200;
    i_first_address_qualifier[4*24+:24] = 24'h000300;
    i_second_address_qualifier[4*24+:24] = 24'h000400;
    i_second_address_qualifier[7*24+:24] = 24'hFFFFFF;
    i_qual_one_en = 16'h0038;
    i_qual_two_en = 16'h8018;
    i_range_mode = 16'h0098;
    {i_rng_trigger, i_rng_record, i_rng_flag_on} = {3{16'h0008}};
    i_rng_flag_off = 16'h0010;
    i_rng_break = 16'h0088;
    i_eq_brk_one = 16'h0020;
    i_eq_rec_two = 16'h8000;
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'h1;
    step(24'h000446, 1'h1, 5'h11);
    step(24'h000445, 1'h1, 5'h00);
    step(24'h000446, 1'h0, 5'h00);
    step(24'h00A000, 1'h1, 5'h14);
    step(24'h000777, 1'h1, 5'h00);
    step(24'h000100, 1'h1, 5'h1F);
    step(24'h0001FF, 1'h1, 5'h1F);
    step(24'h000200, 1'h1, 5'h02);
    step(24'h000300, 1'h1, 5'h10);
    step(24'h0000FF, 1'h1, 5'h00);
    // Level gating on, level 2 selected
    i_gate_en = 1'h1;
    i_gate_level = 3'h2;
    step(24'h000446, 1'h1, 5'h00);
    i_level_true = 6'h02;
    step(24'h000446, 1'h1, 5'h11);
    i_gate_level = 3'h7;
    step(24'h000446, 1'h1, 5'h00);
    i_gate_en = 1'h0;
    step(24'h000446, 1'h1, 5'h11);
    // Sync on: flush the delay line before judging it
    want = 24'h0;
    i_sync_en = 1'h1;
    repeat (3) @(negedge i_clk);
    step(24'h000446, 1'h1, 5'h00);
    step(24'h000000, 1'h1, 5'h00);
    step(24'h000000, 1'h1, 5'h11);
    step(24'h000000, 1'h1, 5'h00);
    results();
  end
endmodule : testbench
`default_nettype wire
